// ==== design/psm_pin.sv ====
// One pin's mapping register and direction logic.
// Assumes the parent decodes the bus and supplies a write strobe.
`timescale 1ns/1ns
module psm_pin #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clk_en,
  // Register write
  input  wire logic                          wr_en,
  input  wire logic [7:0]                    wr_data,
  output logic [7:0]                         map_r,
  // Pin
  input  wire logic                          pin_in,
  output logic                               pin_out,
  output logic                               pin_oe,
  // Tables
  input  wire logic [psm_pkg::TABLE_BITS-1:0] status_tbl,
  output logic                               ctrl_valid,
  output logic [psm_pkg::SEL_W-1:0]          ctrl_sel,
  output logic                               ctrl_level
);

  logic pin_sync;
  logic is_status;
  logic [psm_pkg::SEL_W-1:0] sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_r <= RST_VAL;
    end else if (clk_en && wr_en) begin
      map_r <= wr_data;
    end
  end

  assign sel       = map_r[psm_pkg::SEL_LSB +: psm_pkg::SEL_W];
  assign is_status = map_r[psm_pkg::DIR_BIT];

  psm_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // Status direction: the pin shows the selected status bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (clk_en) begin
      pin_out <= is_status & status_tbl[sel];
      pin_oe  <= is_status;
    end
  end

  assign ctrl_valid = !is_status;
  assign ctrl_sel   = sel;
  assign ctrl_level = pin_sync;

endmodule // psm_pin

// ==== design/psm_pkg.sv ====
// Package for the pin signal mapper: register map, field layout, resets.
// Assumes a 32-bit APB master and word-index offsets as printed.
package psm_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned PIN_COUNT   = 8;
  localparam int unsigned TABLE_BITS  = 128;
  localparam int unsigned SEL_W       = 7;
  localparam int unsigned MAP_W       = 8;

  // ****************************************************************
  // Field layout of a mapping register
  // ****************************************************************
  localparam int unsigned SEL_LSB     = 0;
  localparam int unsigned DIR_BIT     = 7;

  // ****************************************************************
  // Register offsets (word indices, not byte addresses)
  // ****************************************************************
  localparam logic [7:0] PIN0_MAP_OFS = 8'he0;
  localparam logic [7:0] PIN1_MAP_OFS = 8'he1;
  localparam logic [7:0] PIN2_MAP_OFS = 8'he2;
  localparam logic [7:0] PIN3_MAP_OFS = 8'he3;
  localparam logic [7:0] PIN4_MAP_OFS = 8'he4;
  localparam logic [7:0] PIN5_MAP_OFS = 8'he5;
  localparam logic [7:0] PIN6_MAP_OFS = 8'he6;
  localparam logic [7:0] PIN7_MAP_OFS = 8'he7;

  // Offsets not all multiples of four: each is an index, byte address x4.
  localparam logic [11:0] MAP_BASE_ADDR = 12'h380;
  localparam logic [11:0] CTRL_TBL_ADDR = 12'h400;
  localparam logic [11:0] STAT_TBL_ADDR = 12'h410;
  localparam logic [11:0] PIN_LVL_ADDR  = 12'h420;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PIN0_MAP_RST = 8'h00;
  localparam logic [7:0] PINX_MAP_RST = 8'h00;
  localparam logic [7:0] PIN2_MAP_RST = 8'h60;

endpackage

// ==== design/psm_sync.sv ====
// Three-stage synchroniser for one pin level.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/1ns
module psm_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (clk_en) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // The level changes only once the last two stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
    end else if (clk_en && (s2_r == s3_r)) begin
      sync_out <= s3_r;
    end
  end

endmodule // psm_sync

// ==== design/psm_top.sv ====
// Pin signal mapper top: APB slave, eight pin slices, control table.
// Assumes a single pclk domain and an APB master per the bus protocol.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
// How it works
// - Each mapping register bits 6..0 select one table bit for the pin.
// - Control and status tables hold 128 bits, any selectable by any pin, except control bit 0 (map value 0 is unused).
// - Direction bit 0 makes the pin a control input driving its bit.
// - Direction bit 1 drives the pin from the selected status bit.
// - Pins 0, 1 and 3 to 7 reset to zero, meaning unused.
// - Pin 2 resets to 0x60, a control input enabling first diff output.
module psm_top (
  // Clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           clk_en,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Pins
  input  wire logic [psm_pkg::PIN_COUNT-1:0]  pin_in,
  output logic [psm_pkg::PIN_COUNT-1:0]       pin_out,
  output logic [psm_pkg::PIN_COUNT-1:0]       pin_oe,
  // Tables
  input  wire logic [psm_pkg::TABLE_BITS-1:0] status_tbl,
  output logic [psm_pkg::TABLE_BITS-1:0]      ctrl_tbl_r,
  output logic                                first_precision_diff_output
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  localparam logic [7:0] RST_TAB [psm_pkg::PIN_COUNT] = '{
    psm_pkg::PIN0_MAP_RST, psm_pkg::PINX_MAP_RST,
    psm_pkg::PIN2_MAP_RST, psm_pkg::PINX_MAP_RST,
    psm_pkg::PINX_MAP_RST, psm_pkg::PINX_MAP_RST,
    psm_pkg::PINX_MAP_RST, psm_pkg::PINX_MAP_RST};

  logic                                  access;
  logic                                  map_hit;
  logic [2:0]                            map_idx;
  logic [1:0]                            tbl_word;
  logic                                  ctrl_hit;
  logic                                  stat_hit;
  logic                                  lvl_hit;
  logic [7:0]                            map_q [psm_pkg::PIN_COUNT];
  logic [psm_pkg::PIN_COUNT-1:0]         c_valid;
  logic [psm_pkg::SEL_W-1:0]             c_sel [psm_pkg::PIN_COUNT];
  logic [psm_pkg::PIN_COUNT-1:0]         c_lvl;
  logic [psm_pkg::TABLE_BITS-1:0]        ctrl_nxt;
  logic [31:0]                           rdata_nxt;

  assign access  = psel & penable;
  assign map_hit = (paddr[11:5] == psm_pkg::MAP_BASE_ADDR[11:5])
                 & (paddr[1:0] == 2'h0);
  assign map_idx = paddr[4:2];
  assign tbl_word = paddr[3:2];
  assign ctrl_hit = (paddr[11:4] == psm_pkg::CTRL_TBL_ADDR[11:4])
                  & (paddr[1:0] == 2'h0);
  assign stat_hit = (paddr[11:4] == psm_pkg::STAT_TBL_ADDR[11:4])
                  & (paddr[1:0] == 2'h0);
  assign lvl_hit  = (paddr == psm_pkg::PIN_LVL_ADDR);

  // Zero wait states: every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable
                 & ~(map_hit | ctrl_hit | stat_hit | lvl_hit);

  // ****************************************************************
  // Pin slices
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < psm_pkg::PIN_COUNT; g++) begin : g_pin
      psm_pin #(
        .RST_VAL (RST_TAB[g])
      ) u_pin (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .wr_en      (access & pwrite & map_hit
                     & (map_idx == 3'(g))),
        .wr_data    (pwdata[7:0]),
        .map_r      (map_q[g]),
        .pin_in     (pin_in[g]),
        .pin_out    (pin_out[g]),
        .pin_oe     (pin_oe[g]),
        .status_tbl (status_tbl),
        .ctrl_valid (c_valid[g]),
        .ctrl_sel   (c_sel[g]),
        .ctrl_level (c_lvl[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Control table
  // ****************************************************************
  // Software writes a word first; a pin that is a control input then
  // overrides its bit, higher pin number winning on a shared bit.
  always_comb begin
    ctrl_nxt = ctrl_tbl_r;
    if (access && pwrite && ctrl_hit) begin
      ctrl_nxt[32*tbl_word +: 32] = pwdata;
    end
    for (int i = 0; i < psm_pkg::PIN_COUNT; i++) begin
      if (c_valid[i] && map_q[i] != 8'h00) begin
        ctrl_nxt[c_sel[i]] = c_lvl[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_tbl_r <= '0;
    end else if (clk_en) begin
      ctrl_tbl_r <= ctrl_nxt;
    end
  end

  // Bit 0x60 of the control table enables the first diff output.
  assign first_precision_diff_output = ctrl_tbl_r[7'h60];

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (map_hit) begin
      rdata_nxt = {24'h00_0000, map_q[map_idx]};
    end else if (ctrl_hit) begin
      rdata_nxt = ctrl_tbl_r[32*tbl_word +: 32];
    end else if (stat_hit) begin
      rdata_nxt = status_tbl[32*tbl_word +: 32];
    end else if (lvl_hit) begin
      // Synchronised levels only: the raw pins are not safe to register.
      rdata_nxt = {24'h00_0000, c_lvl};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

endmodule // psm_top

// ==== testbench/psm_board.sv ====
// Board logic on the far side of the eight pins.
// Assumes the bench sets the board's own drive levels.
`timescale 1ns/1ns
module psm_board #(
  parameter int LAG = 3
) (
  // Board drive
  input  wire logic [7:0] drive,
  // Device pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_in
);
  // The wire shows the device where it drives, else the board, late.
  assign #LAG pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule // psm_board

// ==== testbench/psm_properties.sv ====
// Port checker for the pin signal mapper.
// Assumes one pclk domain; bound to psm_top below.
`timescale 1ns/1ns
module psm_properties (
  // Clock, reset and bus
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         clk_en,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // Pins and tables
  input wire logic [7:0]   pin_in,
  input wire logic [7:0]   pin_out,
  input wire logic [7:0]   pin_oe,
  input wire logic [127:0] status_tbl,
  input wire logic [127:0] ctrl_tbl_r,
  input wire logic         first_precision_diff_output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Ages of the last causes
  // ****
  logic       wr_take;
  logic [3:0] wr_age_r;
  logic [3:0] st_age_r;
  logic [3:0] pin_age_r;
  assign wr_take = psel && penable && pwrite && clk_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_age_r  <= 4'hf;
      st_age_r  <= 4'hf;
      pin_age_r <= 4'hf;
    end else begin
      wr_age_r  <= wr_take ? 4'h0 : wr_age_r + {3'h0, ~&wr_age_r};
      st_age_r  <= $changed(status_tbl) ? 4'h0
                   : st_age_r + {3'h0, ~&st_age_r};
      pin_age_r <= $changed(pin_in) ? 4'h0
                   : pin_age_r + {3'h0, ~&pin_age_r};
    end
  end
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_zero: assert property (psel && penable && !pwrite && pslverr
    |-> prdata == 32'h0) else $error("refused read not zero");
  a_map_upper: assert property (
    psel && penable && !pwrite && paddr[11:5] == 7'h1c
    |-> prdata[31:8] == 24'h0) else $error("map upper bits set");
  a_diff_tied: assert property (
    first_precision_diff_output == ctrl_tbl_r[96])
    else $error("diff enable not table bit");
  a_reset_quiet: assert property (!$past(presetn)
    |-> pin_oe == 8'h0 && ctrl_tbl_r == 128'h0)
    else $error("state after reset");
  a_oe_by_write: assert property (
    $changed(pin_oe) |-> wr_age_r <= 4'h2) else $error("oe changed");
  a_out_cause: assert property (
    $changed(pin_out) |-> st_age_r <= 4'h1 || wr_age_r <= 4'h3)
    else $error("pin_out changed");
  a_ctrl_synced: assert property (
    $changed(ctrl_tbl_r) |-> pin_age_r >= 4'h2 || wr_age_r <= 4'h3)
    else $error("control table too early");
  c_refused: cover property (pslverr);
  c_status: cover property (|pin_oe && $changed(pin_out));
  c_diff_on: cover property ($rose(first_precision_diff_output));
endmodule // psm_properties

bind psm_top psm_properties u_chk (.*);

// ==== testbench/psm_top_test.sv ====
// Self-checking bench for psm_top with the board model on the pins.
// Assumes the design, board model and checker are compiled first.
`timescale 1ns/1ns
module psm_top_test;
  localparam logic [11:0] MAP = psm_pkg::MAP_BASE_ADDR;
  logic         pclk, presetn, clk_en, psel, penable, pwrite;
  logic [11:0]  paddr, a;
  logic [31:0]  pwdata, prdata, v;
  logic         pready, pslverr, first_precision_diff_output;
  logic [7:0]   pin_in, pin_out, pin_oe, drive;
  logic [127:0] status_tbl, ctrl_tbl_r;
  logic [32:0]  exp_q[$];
  logic [6:0]   sel;
  int           fail_count, checks;
  psm_top dut (.*);
  psm_board board (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****
  // Tasks
  // ****
  task automatic cmp(input string nm, input logic [32:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic rst();
    presetn <= 1'b0;
    tick(8);
    presetn <= 1'b1;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask
  // Read results are matched against the oldest expectation.
  always @(posedge pclk)
    if (psel && penable && !pwrite && exp_q.size() > 0)
      cmp("prdata", exp_q.pop_front(), {pslverr, prdata});
  initial begin
    {presetn, psel, penable, pwrite, clk_en} = 5'b00001;
    {paddr, pwdata, drive, status_tbl} = '0;
    fail_count = 0;
    checks = 0;
    void'($urandom(10));
    rst();
    for (int i = 0; i < 8; i++)
      apb(1'b0, MAP + 12'(4 * i), 32'h0, (i == 2) ?
          33'(psm_pkg::PIN2_MAP_RST) : 33'(psm_pkg::PINX_MAP_RST));
    apb(1'b0, 12'h7fc, 32'h0, 33'h1_0000_0000);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      apb(1'b1, MAP + 12'(4 * i), v, 33'h0);
      apb(1'b0, MAP + 12'(4 * i), 32'h0, {25'h0, v[7:0]});
    end
    rst();
    drive <= 8'h04;
    tick(8);
    cmp("diff", 33'h1, {32'h0, first_precision_diff_output});
    drive <= 8'h00;
    tick(8);
    for (int k = 0; k < 2; k++) begin
      sel = k ? 7'h7f : 7'($urandom_range(95, 1));
      a = psm_pkg::CTRL_TBL_ADDR + 12'({sel[6:5], 2'h0});
      apb(1'b1, MAP, {25'h0, sel}, 33'h0);
      drive <= 8'h01;
      tick(8);
      apb(1'b0, a, 32'h0, 33'h1 << sel[4:0]);
      drive <= 8'h00;
      tick(8);
      apb(1'b0, a, 32'h0, 33'h0);
    end
    sel = 7'($urandom);
    status_tbl <= {$urandom, $urandom, $urandom, $urandom};
    apb(1'b1, MAP + 12'hc, {24'h0, 1'b1, sel}, 33'h0);
    for (int k = 0; k < 2; k++) begin
      tick(3);
      cmp("pin_oe", 33'h8, {25'h0, pin_oe});
      cmp("pin_out", {32'h0, status_tbl[sel]}, {32'h0, pin_out[3]});
      status_tbl[sel] <= ~status_tbl[sel];
    end
    tick(1);
    apb(1'b0, psm_pkg::STAT_TBL_ADDR, 32'h0, {1'b0, status_tbl[31:0]});
    clk_en <= 1'b0;
    apb(1'b1, MAP + 12'h10, 32'haa, 33'h0);
    clk_en <= 1'b1;
    apb(1'b0, MAP + 12'h10, 32'h0, 33'h0);
    v = $urandom;
    apb(1'b1, psm_pkg::CTRL_TBL_ADDR + 12'h4, v, 33'h0);
    apb(1'b0, psm_pkg::CTRL_TBL_ADDR + 12'h4, 32'h0, {1'b0, v});
    test_done();
  end
endmodule // psm_top_test
